// *** rtl/baud_ctrl_pkg.sv ***
// constants, types and register map of the baud rate control block
package baud_ctrl_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DIV_LO = 8'h04;
    localparam logic [7:0] ADDR_DIV_HI = 8'h08;
    localparam logic [7:0] ADDR_MODE   = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h14;
    // control register bit positions
    localparam int unsigned B_ROLL  = 7;
    localparam int unsigned B_IDLE  = 6;
    localparam int unsigned B_SYNC_CLOCK_POLARITY  = 4;
    localparam int unsigned B_WIDE  = 3;
    localparam int unsigned B_WUE   = 1;
    localparam int unsigned B_AUTOBAUD_ENABLE = 0;
    // mode register and interrupt bit positions
    localparam int unsigned B_SYNC  = 0;
    localparam int unsigned B_HS    = 1;
    localparam int unsigned IRQ_WAKE = 0;
    localparam int unsigned IRQ_ABD  = 1;
    localparam int unsigned IRQ_ROLL = 2;
    localparam int unsigned IRQ_N    = 3;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [7:0] DIV_RST  = 8'h00;
    // clock cycles per bit per divisor step
    localparam int unsigned PRE_SLOW = 64;
    localparam int unsigned PRE_FAST = 16;
    localparam int unsigned PRE_SYNC = 4;
    // sync character spans this many bit times between 1st and 5th falling edge
    localparam int unsigned ABD_BITS = 8;
    localparam logic [2:0] ABD_LAST_FALL = 3'h3;
    // reference settings used by the rate checks
    localparam int unsigned REF_DIV_SLOW = 64;
    localparam int unsigned REF_DIV_FAST = 255;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic rollover;
        logic sync_clock_polarity;
        logic wide;
        logic wakeup_monitor_enable;
        logic autobaud_enable;
    } ctrl_s;

    typedef struct packed {
        logic        sync_mode;
        logic        high_speed;
        logic        wide;
        logic [15:0] divisor;
    } brg_cfg_s;

    typedef enum logic [1:0] {
        AB_IDLE = 2'b00,
        AB_WAIT = 2'b01,
        AB_MEAS = 2'b10
    } abd_state_e;
endpackage

// *** rtl/baud_generator.sv ***
// baud generator: one-cycle bit tick from the divisor and mode
`timescale 1ns/1ps
`default_nettype none
module baud_generator
    import baud_ctrl_pkg::*;
#(
    parameter int unsigned CNT_WIDTH = 23
) (
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire brg_cfg_s cfg,
    output logic          bit_tick
);
    generate
        if (CNT_WIDTH < 23) begin : g_chk
            $error("baud_generator: CNT_WIDTH too small");
        end
    endgenerate

    logic [CNT_WIDTH-1:0] cnt_q;
    logic [CNT_WIDTH-1:0] cnt_d;
    logic                 tick_q;
    logic                 tick_d;
    logic [16:0]          steps;
    logic [CNT_WIDTH-1:0] period;

    // steps per bit and cycles per step from the mode
    always_comb begin
        steps = cfg.wide ? ({1'b0, cfg.divisor} + 17'h0_0001)
                         : ({9'h000, cfg.divisor[7:0]} + 17'h0_0001);
        if (cfg.sync_mode || (cfg.wide && cfg.high_speed)) begin
            period = CNT_WIDTH'(steps) * CNT_WIDTH'(PRE_SYNC);
        end else if (cfg.wide || cfg.high_speed) begin
            period = CNT_WIDTH'(steps) * CNT_WIDTH'(PRE_FAST);
        end else begin
            period = CNT_WIDTH'(steps) * CNT_WIDTH'(PRE_SLOW);
        end
    end

    // down counter, tick at zero
    always_comb begin
        tick_d = 1'b0;
        cnt_d  = cnt_q - CNT_WIDTH'(1);
        if (cnt_q == '0 || cnt_q >= period) begin
            tick_d = 1'b1;
            cnt_d  = period - CNT_WIDTH'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign bit_tick = tick_q;
endmodule
`default_nettype wire

// *** rtl/baud_rate_control.sv ***
// baud rate control: registers, auto-baud, wake-up monitor, interrupts
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module baud_rate_control
    import baud_ctrl_pkg::*;
#(
    parameter int unsigned ABD_CNT_WIDTH = 26
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_pin,
    input  wire logic        rx_busy,
    output logic             bit_tick,
    output logic             clk_idle_level,
    output logic             irq
);
    generate
        if (ABD_CNT_WIDTH < 26) begin : g_chk
            $error("baud_rate_control: ABD_CNT_WIDTH too small");
        end
    endgenerate

    ctrl_s                    ctrl_q, ctrl_d;
    logic [7:0]               div_lo_q, div_lo_d, div_hi_q, div_hi_d;
    logic [1:0]               mode_q, mode_d;
    logic [IRQ_N-1:0]         ist_q, ist_d, imask_q, imask_d;
    abd_state_e               ab_q, ab_d;
    logic [ABD_CNT_WIDTH-1:0] ab_cnt_q, ab_cnt_d, quot;
    logic [2:0]               falls_q, falls_d;
    logic                     wake_seen_q, wake_seen_d;
    logic                     rx_meta_q, rx_sync_q, rx_prev_q;
    logic                     bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]               bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]              rdata_q, rdata_d;
    logic                     idle_q;
    logic                     wr_en, rd_en, rx_fall, rx_rise, async_mode;
    logic                     ev_wake, ev_abd, ev_roll, rx_idle;
    logic [7:0]               ctrl_view;
    brg_cfg_s                 cfg;

    // pin synchroniser, edge detection after the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end
    assign rx_fall    = rx_prev_q & ~rx_sync_q;
    assign rx_rise    = ~rx_prev_q & rx_sync_q;
    assign async_mode = ~mode_q[B_SYNC];
    assign rx_idle    = ~(rx_busy | (ab_q == AB_MEAS));

    // control register read view
    always_comb begin
        ctrl_view          = 8'h00;
        ctrl_view[B_ROLL]  = ctrl_q.rollover;
        ctrl_view[B_IDLE]  = rx_idle;
        ctrl_view[B_SYNC_CLOCK_POLARITY]  = ctrl_q.sync_clock_polarity;
        ctrl_view[B_WIDE]  = ctrl_q.wide;
        ctrl_view[B_WUE]   = ctrl_q.wakeup_monitor_enable;
        ctrl_view[B_AUTOBAUD_ENABLE] = ctrl_q.autobaud_enable;
    end

    // bus handshakes: write needs address and data together
    assign wr_en         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign rd_en         = s_axi_arvalid & ~rvalid_q;
    assign s_axi_awready = wr_en;
    assign s_axi_wready  = wr_en;
    assign s_axi_arready = rd_en;

    // quotient of the measured count per divisor step
    always_comb begin
        if (mode_q[B_HS] && ctrl_q.wide) begin
            quot = ab_cnt_q / ABD_CNT_WIDTH'(ABD_BITS * PRE_SYNC);
        end else if (mode_q[B_HS] || ctrl_q.wide) begin
            quot = ab_cnt_q / ABD_CNT_WIDTH'(ABD_BITS * PRE_FAST);
        end else begin
            quot = ab_cnt_q / ABD_CNT_WIDTH'(ABD_BITS * PRE_SLOW);
        end
    end

    // registers, auto-baud and wake-up next state
    always_comb begin
        ctrl_d      = ctrl_q;
        div_lo_d    = div_lo_q;
        div_hi_d    = div_hi_q;
        mode_d      = mode_q;
        imask_d     = imask_q;
        ab_d        = ab_q;
        ab_cnt_d    = ab_cnt_q;
        falls_d     = falls_q;
        wake_seen_d = wake_seen_q;
        ev_wake     = 1'b0;
        ev_abd      = 1'b0;
        ev_roll     = 1'b0;
        ist_d       = ist_q;
        bvalid_d    = bvalid_q & ~s_axi_bready;
        bresp_d     = bresp_q;
        rvalid_d    = rvalid_q & ~s_axi_rready;
        rresp_d     = rresp_q;
        rdata_d     = rdata_q;
        if (wr_en) begin
            bvalid_d = 1'b1;
            bresp_d  = AXI_OKAY;
            if (s_axi_wstrb[0]) begin
                unique case (s_axi_awaddr)
                    ADDR_CTRL: begin
                        ctrl_d.rollover = s_axi_wdata[B_ROLL];
                        ctrl_d.sync_clock_polarity     = s_axi_wdata[B_SYNC_CLOCK_POLARITY];
                        ctrl_d.wide     = s_axi_wdata[B_WIDE];
                        ctrl_d.wakeup_monitor_enable      = s_axi_wdata[B_WUE];
                        ctrl_d.autobaud_enable    = s_axi_wdata[B_AUTOBAUD_ENABLE];
                    end
                    ADDR_DIV_LO: div_lo_d = s_axi_wdata[7:0];
                    ADDR_DIV_HI: div_hi_d = s_axi_wdata[7:0];
                    ADDR_MODE:   mode_d = s_axi_wdata[1:0];
                    ADDR_IRQ_ST: ist_d = ist_q & ~s_axi_wdata[IRQ_N-1:0];
                    ADDR_IRQ_MK: imask_d = s_axi_wdata[IRQ_N-1:0];
                    default:     bresp_d = AXI_SLVERR;
                endcase
            end
        end
        if (rd_en) begin
            rvalid_d = 1'b1;
            rresp_d  = AXI_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL:   rdata_d = {24'h00_0000, ctrl_view};
                ADDR_DIV_LO: rdata_d = {24'h00_0000, div_lo_q};
                ADDR_DIV_HI: rdata_d = {24'h00_0000, div_hi_q};
                ADDR_MODE:   rdata_d = {30'h0000_0000, mode_q};
                ADDR_IRQ_ST: rdata_d = {29'h0000_0000, ist_q};
                ADDR_IRQ_MK: rdata_d = {29'h0000_0000, imask_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = AXI_SLVERR;
                end
            endcase
        end
        // wake-up monitor, pin ignored while disabled
        if (ctrl_q.wakeup_monitor_enable && async_mode) begin
            if (rx_fall) begin
                ev_wake     = 1'b1;
                wake_seen_d = 1'b1;
            end else if (rx_rise && wake_seen_q) begin
                ctrl_d.wakeup_monitor_enable  = 1'b0;
                wake_seen_d = 1'b0;
            end
        end else begin
            wake_seen_d = 1'b0;
        end
        // auto-baud: count from 1st to 5th falling edge of 55h
        unique case (ab_q)
            AB_IDLE: begin
                if (ctrl_q.autobaud_enable && async_mode) begin
                    ab_d = AB_WAIT;
                end
            end
            AB_WAIT: begin
                if (!ctrl_q.autobaud_enable || !async_mode) begin
                    ab_d = AB_IDLE;
                end else if (rx_fall) begin
                    ab_d     = AB_MEAS;
                    ab_cnt_d = ABD_CNT_WIDTH'(1);
                    falls_d  = 3'h0;
                end
            end
            AB_MEAS: begin
                ab_cnt_d = ab_cnt_q + ABD_CNT_WIDTH'(1);
                if (quot > ABD_CNT_WIDTH'(ctrl_q.wide ? 17'h1_0000 : 17'h0_0100)) begin
                    ev_roll      = 1'b1;
                    ctrl_d.autobaud_enable = 1'b0;
                    ab_d         = AB_IDLE;
                end else if (rx_fall) begin
                    falls_d = falls_q + 3'h1;
                    if (falls_q == ABD_LAST_FALL) begin
                        {div_hi_d, div_lo_d} = quot[15:0] - 16'h0001;
                        ctrl_d.autobaud_enable = 1'b0;
                        ev_abd       = 1'b1;
                        ab_d         = AB_IDLE;
                    end
                end
            end
            default: ab_d = AB_IDLE;
        endcase
        // hardware set wins over a software clear
        if (ev_roll) begin
            ctrl_d.rollover = 1'b1;
        end
        ist_d = ist_d | {ev_roll, ev_abd, ev_wake};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q      <= '0;
            div_lo_q    <= DIV_RST;
            div_hi_q    <= DIV_RST;
            mode_q      <= '0;
            ist_q       <= '0;
            imask_q     <= '0;
            ab_q        <= AB_IDLE;
            ab_cnt_q    <= '0;
            falls_q     <= '0;
            wake_seen_q <= 1'b0;
            bvalid_q    <= 1'b0;
            bresp_q     <= AXI_OKAY;
            rvalid_q    <= 1'b0;
            rresp_q     <= AXI_OKAY;
            rdata_q     <= 32'h0000_0000;
            idle_q      <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            div_lo_q    <= div_lo_d;
            div_hi_q    <= div_hi_d;
            mode_q      <= mode_d;
            ist_q       <= ist_d;
            imask_q     <= imask_d;
            ab_q        <= ab_d;
            ab_cnt_q    <= ab_cnt_d;
            falls_q     <= falls_d;
            wake_seen_q <= wake_seen_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            rvalid_q    <= rvalid_d;
            rresp_q     <= rresp_d;
            rdata_q     <= rdata_d;
            idle_q      <= mode_q[B_SYNC] & ctrl_q.sync_clock_polarity;
        end
    end

    assign s_axi_bvalid   = bvalid_q;
    assign s_axi_bresp    = bresp_q;
    assign s_axi_rvalid   = rvalid_q;
    assign s_axi_rresp    = rresp_q;
    assign s_axi_rdata    = rdata_q;
    assign clk_idle_level = idle_q;
    assign irq            = |(ist_q & imask_q);

    // baud generator configuration
    assign cfg = '{sync_mode: mode_q[B_SYNC], high_speed: mode_q[B_HS],
                   wide: ctrl_q.wide, divisor: {div_hi_q, div_lo_q}};

    baud_generator #(.CNT_WIDTH(23)) u_brg (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .cfg      (cfg),
        .bit_tick (bit_tick)
    );

    // helper: cycles between ticks under an unchanged configuration
    logic [22:0] gap_q;
    logic        same_q;
    logic        steady;
    brg_cfg_s    cfg_prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q      <= '0;
            same_q     <= 1'b0;
            cfg_prev_q <= '0;
        end else begin
            cfg_prev_q <= cfg;
            gap_q      <= bit_tick ? 23'h00_0001 : gap_q + 23'h00_0001;
            same_q     <= (cfg == cfg_prev_q) && (bit_tick || same_q);
        end
    end
    // gap only trusted while the setting did not move in the sampled cycle either
    assign steady = same_q && (cfg == cfg_prev_q);

    sequence s_wake_fall;
        ctrl_q.wakeup_monitor_enable && async_mode && rx_fall;
    endsequence
    sequence s_wake_rise;
        ctrl_q.wakeup_monitor_enable && async_mode && wake_seen_q && rx_rise && !rx_fall;
    endsequence

    chk_abd_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_abd |=> !ctrl_q.autobaud_enable && ab_q == AB_IDLE && ist_q[IRQ_ABD])
        else $error("auto-baud enable not cleared after measurement");
    chk_wake_irq_set: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wake_fall |=> ist_q[IRQ_WAKE] && wake_seen_q)
        else $error("wake falling edge did not raise status");
    chk_wake_self_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wake_rise |=> !ctrl_q.wakeup_monitor_enable)
        else $error("wake enable not cleared on rising edge");
    chk_wake_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl_q.wakeup_monitor_enable && !ist_q[IRQ_WAKE]) |=> !ist_q[IRQ_WAKE])
        else $error("wake status set while monitor disabled");
    chk_clk_idle_pol: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 clk_idle_level == $past(mode_q[B_SYNC] & ctrl_q.sync_clock_polarity))
        else $error("sync clock idle level wrong");
    chk_narrow_div: assert property (@(posedge aclk) disable iff (!aresetn)
        (bit_tick && steady && !cfg.wide && !cfg.sync_mode && cfg.high_speed)
        |-> gap_q == 23'(({15'h0000, cfg.divisor[7:0]} + 23'h1) * PRE_FAST))
        else $error("high divisor byte not ignored in narrow mode");
    chk_idle_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_en && s_axi_araddr == ADDR_CTRL) |=> s_axi_rdata[B_IDLE] == $past(rx_idle))
        else $error("receive idle status read wrong");
    chk_rate_slow: assert property (@(posedge aclk) disable iff (!aresetn)
        (bit_tick && steady && cfg.divisor[7:0] == 8'(REF_DIV_SLOW) && !cfg.wide
         && !cfg.high_speed && !cfg.sync_mode) |-> gap_q == 23'(CLK_HZ / 9615))
        else $error("slow rate period not 4160 cycles");
    chk_rate_fast: assert property (@(posedge aclk) disable iff (!aresetn)
        (bit_tick && steady && cfg.divisor[7:0] == 8'(REF_DIV_FAST) && !cfg.wide
         && cfg.high_speed && !cfg.sync_mode) |-> gap_q == 23'((REF_DIV_FAST + 1) * PRE_FAST))
        else $error("fast rate period not 4096 cycles");
    chk_roll_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev_roll || (ctrl_q.rollover && !(wr_en && s_axi_awaddr == ADDR_CTRL)))
        |=> ctrl_q.rollover)
        else $error("rollover flag lost without software clear");
endmodule
`default_nettype wire

// *** testbench/remote_node.sv ***
// remote serial node that drives the receive pin of the block
`timescale 1ns/1ps
`default_nettype none
module remote_node (
    input  wire logic aclk,
    output logic      rx_pin
);
    // line idles at mark, like a pulled-up wire
    initial rx_pin = 1'b1;

    // one frame: start bit, eight data bits lsb first, stop bit
    task automatic send(input logic [7:0] d, input int t);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin <= f[i];
            repeat (t) @(posedge aclk);
        end
    endtask

    // lone low pulse of k cycles, then back to mark
    task automatic pulse(input int k);
        rx_pin <= 1'b0;
        repeat (k) @(posedge aclk);
        rx_pin <= 1'b1;
        @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// *** testbench/test_baud_rate_control.sv ***
// self-checking bench for the baud rate control block
`timescale 1ns/1ps
`default_nettype none
module test_baud_rate_control import baud_ctrl_pkg::*;;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, rx_pin, rx_busy, bit_tick, idle_lvl, irq;
    logic [7:0]  awaddr, araddr, m_ctrl, m_lo, m_hi, m_mode, m_st, m_mk;
    logic [31:0] wdata, rdata, cap_d, seed;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, cap_b, cap_r;
    logic        meas;
    logic [33:0] ex;
    int          bad_count, num_checks, cyc, n;

    baud_rate_control u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_pin(rx_pin), .rx_busy(rx_busy), .bit_tick(bit_tick),
        .clk_idle_level(idle_lvl), .irq(irq)
    );
    remote_node u_node (.aclk(aclk), .rx_pin(rx_pin));

    // 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 96000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // expected response and read data from the reference model
    function automatic logic [33:0] exp(input logic [7:0] a);
        case (a)
            ADDR_CTRL:   return {26'h0, m_ctrl | {1'b0, ~(rx_busy | meas), 6'h0}};
            ADDR_DIV_LO: return {26'h0, m_lo};
            ADDR_DIV_HI: return {26'h0, m_hi};
            ADDR_MODE:   return {26'h0, m_mode};
            ADDR_IRQ_ST: return {26'h0, m_st};
            ADDR_IRQ_MK: return {26'h0, m_mk};
            default:     return {AXI_SLVERR, 32'h0};
        endcase
    endfunction

    // bit period in clocks from the model settings
    function automatic int want_per();
        int p;
        int d;
        d = m_ctrl[B_WIDE] ? {m_hi, m_lo} : m_lo;
        p = PRE_SLOW;
        if (m_mode[B_HS] || m_ctrl[B_WIDE]) p = PRE_FAST;
        if (m_mode[B_SYNC] || (m_mode[B_HS] && m_ctrl[B_WIDE])) p = PRE_SYNC;
        return (d + 1) * p;
    endfunction

    // wait for a handshake, sampled where it is settled before the edge
    task automatic await(input int k);
        logic hit;
        hit = 1'b0;
        while (!hit) begin
            @(negedge aclk);
            hit = (k == 0) ? (awready & wready) : (k == 1) ? bvalid : (k == 2) ? arready : rvalid;
            cap_d = rdata;
            cap_b = bresp;
            cap_r = rresp;
            @(posedge aclk);
        end
    endtask

    // bus write, then model update
    task automatic wm(input logic [7:0] a, input logic [7:0] d);
        seed = lfsr(seed);
        awaddr <= a;
        wdata <= {seed[23:0], d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        await(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        await(1);
        ex = exp(a);
        chk("bresp", {30'h0, ex[33:32]}, {30'h0, cap_b});
        case (a)
            ADDR_CTRL:   m_ctrl = d & 8'h9b;
            ADDR_DIV_LO: m_lo = d;
            ADDR_DIV_HI: m_hi = d;
            ADDR_MODE:   m_mode = d & 8'h03;
            ADDR_IRQ_ST: m_st = m_st & ~d;
            ADDR_IRQ_MK: m_mk = d & 8'h07;
            default:     m_mk = m_mk;
        endcase
    endtask

    // bus read compared with the model
    task automatic rm(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        await(2);
        arvalid <= 1'b0;
        await(3);
        ex = exp(a);
        chk($sformatf("rdata %h", a), ex[31:0], cap_d);
        chk("rresp", {30'h0, ex[33:32]}, {30'h0, cap_r});
    endtask

    // measure one whole bit period after the setting has settled
    task automatic per();
        repeat (2) begin
            do @(negedge aclk); while (bit_tick !== 1'b1);
        end
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (bit_tick !== 1'b1);
        @(posedge aclk);
        chk("period", 32'(want_per()), 32'(n));
    endtask

    task automatic ck_irq();
        chk("irq", {31'h0, |(m_st & m_mk)}, {31'h0, irq});
    endtask

    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_busy, meas} = '0;
        {awaddr, araddr, wdata, m_ctrl, m_lo, m_hi, m_mode, m_st, m_mk} = '0;
        {bad_count, num_checks, cyc} = '0;
        wstrb = 4'hf;
        seed = 32'h0000_9ab2;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a < 7; a++) rm(8'(a * 4));
        rx_busy <= 1'b1;
        @(posedge aclk);
        rm(ADDR_CTRL);
        rx_busy <= 1'b0;
        // idle level of the sync clock over mode and polarity
        for (int i = 0; i < 4; i++) begin
            wm(ADDR_MODE, 8'(i >> 1));
            wm(ADDR_CTRL, 8'((i & 1) << B_SYNC_CLOCK_POLARITY));
            repeat (3) @(posedge aclk);
            chk("idle_lvl", {31'h0, i == 3}, {31'h0, idle_lvl});
        end
        // narrow slow and fast, random high byte must be ignored, then wide slow and fast
        wm(ADDR_MODE, 8'h00);
        wm(ADDR_CTRL, 8'h00);
        wm(ADDR_DIV_HI, seed[7:0] | 8'h01);
        wm(ADDR_DIV_LO, 8'd64);
        per();
        chk("rate", 32'd9615, 32'((CLK_HZ + n / 2) / n));
        wm(ADDR_MODE, 8'h02);
        wm(ADDR_DIV_LO, 8'd255);
        per();
        chk("rate", 32'd9766, 32'((CLK_HZ + n / 2) / n));
        wm(ADDR_MODE, 8'h00);
        wm(ADDR_CTRL, 8'h08);
        wm(ADDR_DIV_HI, 8'h01);
        wm(ADDR_DIV_LO, 8'h04);
        per();
        wm(ADDR_MODE, 8'h02);
        per();
        wm(ADDR_MODE, 8'h00);
        // wake-up: ignored when off, then raise, mask, clear
        wm(ADDR_CTRL, 8'h00);
        wm(ADDR_IRQ_MK, 8'h01);
        u_node.pulse(20);
        repeat (6) @(posedge aclk);
        rm(ADDR_IRQ_ST);
        wm(ADDR_CTRL, 8'h02);
        u_node.pulse(20);
        repeat (6) @(posedge aclk);
        m_st = m_st | 8'h01;
        m_ctrl = m_ctrl & 8'hfd;
        ck_irq();
        rm(ADDR_IRQ_ST);
        rm(ADDR_CTRL);
        wm(ADDR_IRQ_MK, 8'h00);
        ck_irq();
        wm(ADDR_IRQ_MK, 8'h07);
        wm(ADDR_IRQ_ST, 8'h01);
        ck_irq();
        // auto-baud on a sync character, slow narrow setting
        wm(ADDR_CTRL, 8'h01);
        meas = 1'b1;
        fork
            u_node.send(8'h55, 672);
            begin
                repeat (1000) @(posedge aclk);
                rm(ADDR_CTRL);
            end
        join
        meas = 1'b0;
        {m_hi, m_lo} = 16'd9;
        m_ctrl = m_ctrl & 8'hfe;
        m_st = m_st | 8'h02;
        for (int a = 0; a < 6; a++) rm(8'(a * 4));
        // auto-baud overflow on a far too slow character
        wm(ADDR_MODE, 8'h02);
        wm(ADDR_CTRL, 8'h01);
        meas = 1'b1;
        u_node.send(8'h55, 4168);
        meas = 1'b0;
        m_ctrl = (m_ctrl & 8'hfe) | 8'h80;
        m_st = m_st | 8'h04;
        for (int a = 0; a < 6; a++) rm(8'(a * 4));
        ck_irq();
        wm(ADDR_CTRL, 8'h00);
        rm(ADDR_CTRL);
        results();
    end
endmodule
`default_nettype wire
